// ==== core/tpc_timer.sv ====
// Sixteen-bit timer counter with one capture, compare and PWM channel.
// Assumes one core_clk, an 8-bit register port and asynchronous pins.
//
// How it works
// - edge level 00 releases the pin.
// - capture on rising, falling or both edges.
// - compare match toggles, clears or sets pin.
// - edge PWM high-true or low-true pulses.
// - center align gives center PWM unless edge level is 00.
// - capture edges need two stable cycles.
// - channel value bytes reset to zero.
// - capture read freezes both bytes coherently.
// - compare writes transfer after both bytes.
// - center align makes counter count up/down.
// - clock source resets to off.
// - counting halts in background debug.
// - up count wraps at terminal count.
// - up/down endpoints last one tick.
// - overflow request while flag and enable.
// - up overflow at terminal to zero.
// - up/down overflow at reversal at the modulus.
// - counter read captures both bytes.
// - counter write resets count and read latch.
// - channel flag cleared by read then zero.
// - edge PWM updates when counter is zero.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "tpc_regs.svh"

module tpc_timer
	import tpc_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// Register port
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	// System inputs
	input  wire logic       debugActive,
	input  wire logic       fixedClkTick,
	input  wire logic       extClkPin,
	// Channel pin
	input  wire logic       chanPinIn,
	output logic            chanPinOut,
	output logic            chanPinOe_n,
	// Requests
	output logic            overflowIrq,
	output logic            channelIrq
);

	// ----------------------------------------
	// Reset and input synchronisers
	// ----------------------------------------
	logic       rstMeta_reg, rstSync_n;
	logic [1:0] extSync_reg, pinSync_reg;
	logic       extPrev_reg, pinPrev_reg;
	logic [1:0] stableCnt_reg;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_n   <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_n   <= rstMeta_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			extSync_reg <= 2'h0;
			pinSync_reg <= 2'h0;
			extPrev_reg <= 1'b0;
			pinPrev_reg <= 1'b0;
		end else begin
			extSync_reg <= {extSync_reg[0], extClkPin};
			pinSync_reg <= {pinSync_reg[0], chanPinIn};
			extPrev_reg <= extSync_reg[1];
			pinPrev_reg <= pinSync_reg[1];
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic       tofFlag_reg, overflow_irq_enable_reg, center_align_select_reg;
	logic [1:0] clks_reg;
	logic       chf_reg, chie_reg, msb_reg, msa_reg;
	logic [1:0] els_reg;
	logic [15:0] mod_reg, modBuf_reg, cnt_reg, cntBuf_reg, cv_reg, cvBuf_reg;
	logic       modHiW_reg, modLoW_reg, cvHiW_reg, cvLoW_reg;
	logic       cntLatched_reg, cvLatched_reg, chfArmed_reg, countDown_reg;
	tpc_mode_t  mode;

	wire wrTsc  = regWrite && regAddr == `TPC_OFS_TSC;
	wire wrCsc  = regWrite && regAddr == `TPC_OFS_CSC;
	wire wrCnt  = regWrite && (regAddr == `TPC_OFS_CNTH || regAddr == `TPC_OFS_CNTL);
	wire wrCvh  = regWrite && regAddr == `TPC_OFS_CVH;
	wire wrCvl  = regWrite && regAddr == `TPC_OFS_CVL;
	wire wrModh = regWrite && regAddr == `TPC_OFS_MODH;
	wire wrModl = regWrite && regAddr == `TPC_OFS_MODL;
	wire rdCnt  = regRead && (regAddr == `TPC_OFS_CNTH || regAddr == `TPC_OFS_CNTL);
	wire rdCv   = regRead && (regAddr == `TPC_OFS_CVH || regAddr == `TPC_OFS_CVL);
	wire rdCsc  = regRead && regAddr == `TPC_OFS_CSC;

	always_comb begin
		if (els_reg == `TPC_ELS_OFF && !(msa_reg && !msb_reg && !center_align_select_reg))
			mode = TPC_MODE_OFF;
		else if (center_align_select_reg || msb_reg)
			mode = TPC_MODE_PWM;
		else if (msa_reg)
			mode = TPC_MODE_COMPARE;
		else
			mode = TPC_MODE_CAPTURE;
	end

	// ----------------------------------------
	// Clock select and counter
	// ----------------------------------------
	logic tick;
	always_comb begin
		unique case (clks_reg)
			`TPC_CLKS_OFF:   tick = 1'b0;
			`TPC_CLKS_BUS:   tick = 1'b1;
			`TPC_CLKS_FIXED: tick = fixedClkTick;
			`TPC_CLKS_EXT:   tick = extSync_reg[1] && !extPrev_reg;
		endcase
		if (debugActive)
			tick = 1'b0;
	end

	wire [15:0] term   = (mod_reg == `TPC_RST_WORD) ? `TPC_MAX_COUNT : mod_reg;
	wire        upWrap = tick && !center_align_select_reg && cnt_reg == term;
	wire        turn   = tick && center_align_select_reg && !countDown_reg && cnt_reg == mod_reg;
	wire        cpwmRise = tick && center_align_select_reg && countDown_reg && cnt_reg == `TPC_RST_WORD;

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			cnt_reg       <= `TPC_RST_WORD;
			countDown_reg <= 1'b0;
		end else if (wrCnt) begin
			cnt_reg       <= `TPC_RST_WORD;
			countDown_reg <= 1'b0;
		end else if (tick) begin
			if (!center_align_select_reg) begin
				countDown_reg <= 1'b0;
				cnt_reg       <= upWrap ? `TPC_RST_WORD : cnt_reg + 16'h0001;
			end else if (turn) begin
				countDown_reg <= 1'b1;
				cnt_reg       <= cnt_reg - 16'h0001;
			end else if (cpwmRise) begin
				countDown_reg <= 1'b0;
				cnt_reg       <= cnt_reg + 16'h0001;
			end else
				cnt_reg <= countDown_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			cntLatched_reg <= 1'b0;
			cntBuf_reg     <= `TPC_RST_WORD;
		end else if (wrCnt) begin
			cntLatched_reg <= 1'b0;
		end else if (rdCnt) begin
			cntLatched_reg <= !cntLatched_reg;
			if (!cntLatched_reg)
				cntBuf_reg <= cnt_reg;
		end
	end

	// ----------------------------------------
	// Timer control, overflow and modulus
	// ----------------------------------------
	logic tofArmed_reg;
	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			tofFlag_reg  <= 1'b0;
			tofArmed_reg <= 1'b0;
			overflow_irq_enable_reg     <= 1'b0;
			center_align_select_reg    <= 1'b0;
			clks_reg     <= `TPC_CLKS_OFF;
		end else begin
			if (upWrap || turn) begin
				tofFlag_reg  <= 1'b1;
				tofArmed_reg <= 1'b0;
			end else if (wrTsc && tofArmed_reg && !regWrData[`TPC_TSC_TOF])
				tofFlag_reg <= 1'b0;
			if (!(upWrap || turn) && regRead && regAddr == `TPC_OFS_TSC)
				tofArmed_reg <= tofFlag_reg;
			if (wrTsc) begin
				overflow_irq_enable_reg  <= regWrData[`TPC_TSC_OVERFLOW_IRQ_ENABLE];
				center_align_select_reg <= regWrData[`TPC_TSC_CENTER_ALIGN_SELECT];
				clks_reg  <= regWrData[`TPC_TSC_CLKS_HI:`TPC_TSC_CLKS_LO];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			mod_reg    <= `TPC_RST_WORD;
			modBuf_reg <= `TPC_RST_WORD;
			modHiW_reg <= 1'b0;
			modLoW_reg <= 1'b0;
		end else if (wrTsc) begin
			modHiW_reg <= 1'b0;
			modLoW_reg <= 1'b0;
		end else if ((modHiW_reg || wrModh) && (modLoW_reg || wrModl)) begin
			mod_reg    <= {wrModh ? regWrData : modBuf_reg[15:8],
				wrModl ? regWrData : modBuf_reg[7:0]};
			modHiW_reg <= 1'b0;
			modLoW_reg <= 1'b0;
		end else begin
			if (wrModh) begin
				modBuf_reg[15:8] <= regWrData;
				modHiW_reg       <= 1'b1;
			end
			if (wrModl) begin
				modBuf_reg[7:0] <= regWrData;
				modLoW_reg      <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Channel value and flag
	// ----------------------------------------
	wire pinRise = pinSync_reg[1] && !pinPrev_reg;
	wire pinFall = !pinSync_reg[1] && pinPrev_reg;
	wire pinSettled = stableCnt_reg == 2'(`TPC_PIN_STABLE_CYC);
	logic capEvt;
	always_comb begin
		unique case (els_reg)
			`TPC_ELS_RISE: capEvt = pinRise;
			`TPC_ELS_FALL: capEvt = pinFall;
			`TPC_ELS_BOTH: capEvt = pinRise || pinFall;
			default:       capEvt = 1'b0;
		endcase
		capEvt = capEvt && pinSettled && mode == TPC_MODE_CAPTURE;
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n)
			stableCnt_reg <= 2'h0;
		else if (pinSync_reg[1] != pinPrev_reg)
			stableCnt_reg <= 2'h0;
		else if (!pinSettled)
			stableCnt_reg <= stableCnt_reg + 2'h1;
	end

	wire match  = tick && cnt_reg == cv_reg && mode != TPC_MODE_CAPTURE && mode != TPC_MODE_OFF;
	wire chEvt  = capEvt || match;
	wire cvBoth = (cvHiW_reg || wrCvh) && (cvLoW_reg || wrCvl);
	wire [15:0] cvNew = {wrCvh ? regWrData : cvBuf_reg[15:8], wrCvl ? regWrData : cvBuf_reg[7:0]};
	wire cvLoad = center_align_select_reg ? turn : (mode == TPC_MODE_PWM ? cnt_reg == `TPC_RST_WORD : 1'b1);

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			cv_reg        <= `TPC_RST_WORD;
			cvBuf_reg     <= `TPC_RST_WORD;
			cvHiW_reg     <= 1'b0;
			cvLoW_reg     <= 1'b0;
			cvLatched_reg <= 1'b0;
		end else if (wrCsc) begin
			cvHiW_reg     <= 1'b0;
			cvLoW_reg     <= 1'b0;
			cvLatched_reg <= 1'b0;
		end else if (mode == TPC_MODE_CAPTURE) begin
			if (capEvt)
				cv_reg <= cnt_reg;
			if (rdCv) begin
				cvLatched_reg <= !cvLatched_reg;
				if (!cvLatched_reg)
					cvBuf_reg <= cv_reg;
			end
		end else if (cvBoth && cvLoad) begin
			cv_reg    <= cvNew;
			cvHiW_reg <= 1'b0;
			cvLoW_reg <= 1'b0;
		end else begin
			if (wrCvh) begin
				cvBuf_reg[15:8] <= regWrData;
				cvHiW_reg       <= 1'b1;
			end
			if (wrCvl) begin
				cvBuf_reg[7:0] <= regWrData;
				cvLoW_reg      <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			chf_reg      <= 1'b0;
			chfArmed_reg <= 1'b0;
			chie_reg     <= 1'b0;
			msb_reg      <= 1'b0;
			msa_reg      <= 1'b0;
			els_reg      <= `TPC_ELS_OFF;
		end else begin
			if (chEvt) begin
				chf_reg      <= 1'b1;
				chfArmed_reg <= 1'b0;
			end else if (wrCsc && chfArmed_reg && !regWrData[`TPC_CSC_CHF]) begin
				chf_reg      <= 1'b0;
				chfArmed_reg <= 1'b0;
			end else if (rdCsc)
				chfArmed_reg <= chf_reg;
			if (wrCsc) begin
				chie_reg <= regWrData[`TPC_CSC_CHIE];
				msb_reg  <= regWrData[`TPC_CSC_MSB];
				msa_reg  <= regWrData[`TPC_CSC_MSA];
				els_reg  <= regWrData[`TPC_CSC_ELS_HI:`TPC_CSC_ELS_LO];
			end
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// pin action
	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			chanPinOut  <= 1'b0;
			chanPinOe_n <= 1'b1;
		end else begin
			chanPinOe_n <= mode == TPC_MODE_OFF || mode == TPC_MODE_CAPTURE
				|| els_reg == `TPC_ELS_OFF;
			if (mode == TPC_MODE_COMPARE && match) begin
				unique case (els_reg)
					`TPC_ELS_RISE: chanPinOut <= !chanPinOut;
					`TPC_ELS_FALL: chanPinOut <= 1'b0;
					`TPC_ELS_BOTH: chanPinOut <= 1'b1;
					default:       chanPinOut <= chanPinOut;
				endcase
			end else if (mode == TPC_MODE_PWM && !center_align_select_reg) begin
				if (match)
					chanPinOut <= els_reg[0];
				else if (upWrap)
					chanPinOut <= !els_reg[0];
			end else if (mode == TPC_MODE_PWM && match)
				chanPinOut <= countDown_reg ? !els_reg[0] : els_reg[0];
		end
	end

	// ----------------------------------------
	// Register reads and requests
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			regRdData   <= `TPC_RST_BYTE;
			overflowIrq <= 1'b0;
			channelIrq  <= 1'b0;
		end else begin
			overflowIrq <= tofFlag_reg && overflow_irq_enable_reg;
			channelIrq  <= chf_reg && chie_reg;
			regRdData   <= `TPC_RST_BYTE;
			if (regRead) begin
				unique case (regAddr)
					`TPC_OFS_TSC:  regRdData <= {tofFlag_reg, overflow_irq_enable_reg, center_align_select_reg, clks_reg, 3'h0};
					`TPC_OFS_CNTH: regRdData <= cntLatched_reg ? cntBuf_reg[15:8] : cnt_reg[15:8];
					`TPC_OFS_CNTL: regRdData <= cntLatched_reg ? cntBuf_reg[7:0] : cnt_reg[7:0];
					`TPC_OFS_MODH: regRdData <= mod_reg[15:8];
					`TPC_OFS_MODL: regRdData <= mod_reg[7:0];
					`TPC_OFS_CSC:  regRdData <= {chf_reg, chie_reg, msb_reg, msa_reg, els_reg, 2'h0};
					`TPC_OFS_CVH:  regRdData <= cvLatched_reg ? cvBuf_reg[15:8] : cv_reg[15:8];
					`TPC_OFS_CVL:  regRdData <= cvLatched_reg ? cvBuf_reg[7:0] : cv_reg[7:0];
					default:       regRdData <= `TPC_RST_BYTE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_counter_reset: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		wrCnt |=> cnt_reg == 16'h0000 && !cntLatched_reg)
		else $error("Counter write did not reset count.");
	a_up_wrap: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		upWrap && !wrCnt |=> cnt_reg == 16'h0000 && tofFlag_reg)
		else $error("Up counter did not wrap with overflow.");
	a_turn_flag: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		turn && !wrCnt |=> tofFlag_reg && countDown_reg)
		else $error("Reversal did not set overflow.");
	a_irq_level: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		tofFlag_reg && overflow_irq_enable_reg |=> overflowIrq)
		else $error("Overflow request missing.");
	a_clock_off: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		clks_reg == 2'h0 && !wrCnt |=> $stable(cnt_reg))
		else $error("Counter moved with no clock.");
	a_debug_halt: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		debugActive && !wrCnt |=> $stable(cnt_reg))
		else $error("Counter moved in debug.");
	a_pin_release: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		els_reg == 2'h0 |=> chanPinOe_n)
		else $error("Pin not released.");
	a_flag_set: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		chEvt |=> chf_reg)
		else $error("Channel event lost.");
	a_cnt_coherent: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		rdCnt && !cntLatched_reg && !wrCnt |=> cntLatched_reg && cntBuf_reg == $past(cnt_reg))
		else $error("Counter read not captured.");

endmodule // tpc_timer

// ==== core/tpc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the timer channel.
// Assumes an 8-bit register port with byte-wide registers at the offsets below.
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TPC_OFS_TSC      4'h0
`define TPC_OFS_CNTH     4'h1
`define TPC_OFS_CNTL     4'h2
`define TPC_OFS_MODH     4'h3
`define TPC_OFS_MODL     4'h4
`define TPC_OFS_CSC      4'h5
`define TPC_OFS_CVH      4'h6
`define TPC_OFS_CVL      4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPC_TSC_TOF      7
`define TPC_TSC_OVERFLOW_IRQ_ENABLE     6
`define TPC_TSC_CENTER_ALIGN_SELECT    5
`define TPC_TSC_CLKS_HI  4
`define TPC_TSC_CLKS_LO  3
`define TPC_CSC_CHF      7
`define TPC_CSC_CHIE     6
`define TPC_CSC_MSB      5
`define TPC_CSC_MSA      4
`define TPC_CSC_ELS_HI   3
`define TPC_CSC_ELS_LO   2

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define TPC_RST_BYTE     8'h00
`define TPC_RST_WORD     16'h0000
`define TPC_MAX_COUNT    16'hFFFF
`define TPC_CLKS_OFF     2'h0
`define TPC_CLKS_BUS     2'h1
`define TPC_CLKS_FIXED   2'h2
`define TPC_CLKS_EXT     2'h3
`define TPC_ELS_OFF      2'h0
`define TPC_ELS_RISE     2'h1
`define TPC_ELS_FALL     2'h2
`define TPC_ELS_BOTH     2'h3

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define TPC_PIN_STABLE_CYC 2

`endif

// ==== core/tpc_pkg.sv ====
// Types shared by the timer channel design.
// Assumes the constants header is included alongside.
package tpc_pkg;

	typedef enum logic [1:0] {
		TPC_MODE_OFF,
		TPC_MODE_CAPTURE,
		TPC_MODE_COMPARE,
		TPC_MODE_PWM
	} tpc_mode_t;

	typedef enum logic {
		TPC_CPWM_EDGE,
		TPC_CPWM_CENTER
	} tpc_align_t;

endpackage

// ==== verification/tb_top.sv ====
// Self-checking bench for the timer channel: registers, counter, capture, compare.
// Assumes the design header and package are compiled first; bench drives all ports.
`timescale 1ns/100ps
`include "tpc_regs.svh"

module tb_top
	import tpc_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       core_clk;
	logic       reset_n;
	logic [3:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrite;
	logic       regRead;
	logic [7:0] regRdData;
	logic       debugActive;
	logic       fixedClkTick;
	logic       extClkPin;
	logic       chanPinIn;
	logic       chanPinOut;
	logic       chanPinOe_n;
	logic       overflowIrq;
	logic       channelIrq;
	logic       pinBefore;
	int         mismatches;
	int         num_checks;

	typedef struct {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdExp;
		logic       oeExp;
	} tpc_row_t;

	tpc_row_t rows [16] = '{
		'{`TPC_OFS_CSC, 8'h00, 8'h00, 1'b1}, '{`TPC_OFS_CSC, 8'h04, 8'h04, 1'b1},
		'{`TPC_OFS_CSC, 8'h08, 8'h08, 1'b1}, '{`TPC_OFS_CSC, 8'h0C, 8'h0C, 1'b1},
		'{`TPC_OFS_CSC, 8'h10, 8'h10, 1'b1}, '{`TPC_OFS_CSC, 8'h14, 8'h14, 1'b0},
		'{`TPC_OFS_CSC, 8'h18, 8'h18, 1'b0}, '{`TPC_OFS_CSC, 8'h1C, 8'h1C, 1'b0},
		'{`TPC_OFS_CSC, 8'h28, 8'h28, 1'b0}, '{`TPC_OFS_CSC, 8'h24, 8'h24, 1'b0},
		'{`TPC_OFS_CSC, 8'h00, 8'h00, 1'b1}, '{4'h8, 8'hFF, 8'h00, 1'b1},
		'{4'hF, 8'h5A, 8'h00, 1'b1}, '{`TPC_OFS_TSC, 8'h20, 8'h20, 1'b1},
		'{`TPC_OFS_CSC, 8'h08, 8'h08, 1'b0}, '{`TPC_OFS_TSC, 8'h00, 8'h00, 1'b1}
	};

	// ----------------------------------------
	// Design and clock
	// ----------------------------------------
	tpc_timer DUT (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.regAddr      (regAddr),
		.regWrData    (regWrData),
		.regWrite     (regWrite),
		.regRead      (regRead),
		.regRdData    (regRdData),
		.debugActive  (debugActive),
		.fixedClkTick (fixedClkTick),
		.extClkPin    (extClkPin),
		.chanPinIn    (chanPinIn),
		.chanPinOut   (chanPinOut),
		.chanPinOe_n  (chanPinOe_n),
		.overflowIrq  (overflowIrq),
		.channelIrq   (channelIrq)
	);

	always #12.5 core_clk = ~core_clk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrite  <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		chk(regRdData & m, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Holds the fixed clock enable for n edges, so the counter advances n times.
	task automatic tick(input int n);
		@(posedge core_clk);
		fixedClkTick <= 1'b1;
		repeat (n) @(posedge core_clk);
		fixedClkTick <= 1'b0;
		idle(4);
	endtask

	task automatic setPin(input logic v);
		@(posedge core_clk);
		chanPinIn <= v;
		idle(8);
	endtask

	task automatic waitChanIrq();
		int i;
		for (i = 0; i < 50 && channelIrq !== 1'b1; i++) begin
			@(posedge core_clk);
		end
		if (i == 50) begin
			mismatches++;
			$display("CHECK FAILED at %0t: channel request never raised", $time);
			complete_run();
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		debugActive = 1'b0;
		fixedClkTick = 1'b0;
		extClkPin = 1'b0;
		chanPinIn = 1'b0;
		mismatches = 0;
		num_checks = 0;
		idle(4);
		chk({7'h00, chanPinOe_n}, 8'h01);
		reset_n <= 1'b1;
		idle(2);
		// Every register reads zero after reset.
		for (int a = 0; a < 8; a++) begin
			rd(a[3:0], 8'h00);
		end
		// Mode table: write, read back, check pin release.
		for (int r = 0; r < 16; r++) begin
			wr(rows[r].addr, rows[r].wdata);
			rd(rows[r].addr, rows[r].rdExp, 8'h7F);
			chk({7'h00, chanPinOe_n}, {7'h00, rows[r].oeExp});
		end

		// Counter read coherency, debug halt and manual reset.
		wr(`TPC_OFS_TSC, 8'h10);
		wr(`TPC_OFS_CNTH, 8'h00);
		tick(300);
		rd(`TPC_OFS_CNTL, 8'h2C);
		tick(300);
		rd(`TPC_OFS_CNTH, 8'h01);
		rd(`TPC_OFS_CNTH, 8'h02);
		rd(`TPC_OFS_CNTL, 8'h58);
		debugActive <= 1'b1;
		tick(50);
		debugActive <= 1'b0;
		rd(`TPC_OFS_CNTH, 8'h02);
		wr(`TPC_OFS_CNTL, 8'h77);
		tick(5);
		rd(`TPC_OFS_CNTL, 8'h05);
		rd(`TPC_OFS_CNTH, 8'h00);

		// Input capture with read freeze and edge selection.
		wr(`TPC_OFS_CNTH, 8'h00);
		tick(291);
		wr(`TPC_OFS_CSC, 8'h44);
		idle(4);
		setPin(1'b1);
		waitChanIrq();
		rd(`TPC_OFS_CSC, 8'hC4);
		chk({7'h00, channelIrq}, 8'h01);
		rd(`TPC_OFS_CVH, 8'h01);
		setPin(1'b0);
		tick(17);
		setPin(1'b1);
		rd(`TPC_OFS_CVL, 8'h23);
		rd(`TPC_OFS_CVH, 8'h01);
		rd(`TPC_OFS_CVL, 8'h34);
		rd(`TPC_OFS_CSC, 8'hC4);
		wr(`TPC_OFS_CSC, 8'h04);
		rd(`TPC_OFS_CSC, 8'h04);
		chk({7'h00, channelIrq}, 8'h00);
		setPin(1'b0);
		rd(`TPC_OFS_CSC, 8'h04);
		wr(`TPC_OFS_CSC, 8'h08);
		idle(4);
		setPin(1'b1);
		rd(`TPC_OFS_CSC, 8'h08);
		setPin(1'b0);
		rd(`TPC_OFS_CSC, 8'h88);
		wr(`TPC_OFS_CSC, 8'h88);
		rd(`TPC_OFS_CSC, 8'h88);
		wr(`TPC_OFS_CSC, 8'h08);
		rd(`TPC_OFS_CSC, 8'h08);

		// Up count with a modulus, overflow flag and request.
		wr(`TPC_OFS_TSC, 8'h00);
		wr(`TPC_OFS_CNTH, 8'h00);
		wr(`TPC_OFS_MODH, 8'h00);
		wr(`TPC_OFS_MODL, 8'h03);
		idle(4);
		wr(`TPC_OFS_TSC, 8'h50);
		tick(3);
		rd(`TPC_OFS_CNTL, 8'h03);
		rd(`TPC_OFS_CNTH, 8'h00);
		rd(`TPC_OFS_TSC, 8'h50);
		tick(1);
		rd(`TPC_OFS_TSC, 8'hD0);
		chk({7'h00, overflowIrq}, 8'h01);
		rd(`TPC_OFS_CNTL, 8'h00);
		rd(`TPC_OFS_CNTH, 8'h00);
		wr(`TPC_OFS_TSC, 8'h50);
		rd(`TPC_OFS_TSC, 8'h50);
		chk({7'h00, overflowIrq}, 8'h00);

		// Up/down count reverses at the modulus and at zero.
		wr(`TPC_OFS_TSC, 8'h30);
		wr(`TPC_OFS_CNTL, 8'h00);
		tick(3);
		rd(`TPC_OFS_TSC, 8'h30);
		tick(1);
		rd(`TPC_OFS_TSC, 8'hB0);
		rd(`TPC_OFS_CNTL, 8'h02);
		rd(`TPC_OFS_CNTH, 8'h00);
		tick(3);
		rd(`TPC_OFS_CNTL, 8'h01);
		rd(`TPC_OFS_CNTH, 8'h00);
		wr(`TPC_OFS_TSC, 8'h30);

		// Output compare toggles the pin on a match.
		wr(`TPC_OFS_TSC, 8'h00);
		wr(`TPC_OFS_CNTH, 8'h00);
		wr(`TPC_OFS_CSC, 8'h14);
		wr(`TPC_OFS_CVH, 8'h00);
		wr(`TPC_OFS_CVL, 8'h02);
		rd(`TPC_OFS_CVL, 8'h02);
		wr(`TPC_OFS_TSC, 8'h10);
		idle(4);
		pinBefore = chanPinOut;
		tick(3);
		chk({7'h00, chanPinOut}, {7'h00, ~pinBefore});
		chk({7'h00, chanPinOe_n}, 8'h00);
		rd(`TPC_OFS_CSC, 8'h94);

		// Clock sources: external pin at a quarter of the bus rate, then bus clock.
		wr(`TPC_OFS_TSC, 8'h18);
		wr(`TPC_OFS_CNTH, 8'h00);
		repeat (3) begin
			@(posedge core_clk);
			extClkPin <= 1'b1;
			idle(1);
			extClkPin <= 1'b0;
			idle(2);
		end
		idle(4);
		rd(`TPC_OFS_CNTL, 8'h03);
		rd(`TPC_OFS_CNTH, 8'h00);
		wr(`TPC_OFS_TSC, 8'h08);
		wr(`TPC_OFS_CNTH, 8'h00);
		rd(`TPC_OFS_CNTL, 8'h01);
		rd(`TPC_OFS_CNTH, 8'h00);

		// Edge PWM loads its value at zero; center PWM acts on both slopes.
		wr(`TPC_OFS_TSC, 8'h00);
		wr(`TPC_OFS_CNTH, 8'h00);
		wr(`TPC_OFS_CSC, 8'h28);
		wr(`TPC_OFS_TSC, 8'h10);
		tick(2);
		wr(`TPC_OFS_CVH, 8'h00);
		wr(`TPC_OFS_CVL, 8'h01);
		rd(`TPC_OFS_CVL, 8'h02);
		tick(2);
		chk({7'h00, chanPinOut}, 8'h01);
		rd(`TPC_OFS_CVL, 8'h01);
		tick(2);
		chk({7'h00, chanPinOut}, 8'h00);
		wr(`TPC_OFS_TSC, 8'h00);
		wr(`TPC_OFS_CSC, 8'h24);
		wr(`TPC_OFS_CNTH, 8'h00);
		wr(`TPC_OFS_TSC, 8'h30);
		tick(2);
		chk({7'h00, chanPinOut}, 8'h01);
		tick(4);
		chk({7'h00, chanPinOut}, 8'h00);

		// Reset in mid-run returns pin and registers to their reset state.
		reset_n <= 1'b0;
		idle(2);
		chk({6'h00, chanPinOe_n, channelIrq}, 8'h02);
		reset_n <= 1'b1;
		idle(2);
		rd(`TPC_OFS_CVL, 8'h00);
		rd(`TPC_OFS_TSC, 8'h00);

		complete_run();
	end

endmodule // tb_top
